// [verilog/bpc_defines.vh]
// Constants shared by the battery protection configuration register bank
// Summary of operation
// - Latch released only by release bit 0-1-0
// - Control bit 1 turns discharge switch on
// - Control bit 2 turns charge switch on
// - Control bit 3 turns precharge switch off
// - Control bit 4 disables monitoring and balancing
// - Control bit 5 enables LED drive
// - Control bit 6 powers the thermistor
// - Control bit 7 disables shutdown monitor
// - Low nibble selects shutdown threshold, reset zero
// - High nibble selects brownout threshold
// - Five-bit discharge overcurrent threshold, resets zero
// - Five-bit charge overcurrent threshold, resets zero
// - Discharge overcurrent delay 1 ms plus 2 ms/step
// - Charge overcurrent delay, same coding
// - Shared four-bit short threshold, resets zero
// - Discharge short beyond delay turns discharge off
// - Short delay is 61 us per step
// - Charge short beyond delay turns charge off
// - All registers reset at power up
`ifndef BPC_DEFINES_VH
`define BPC_DEFINES_VH
// Register offsets
`define BPC_ADDR_CONTROL 8'h01
`define BPC_ADDR_THRESH 8'h02
`define BPC_ADDR_OCV_DSG 8'h03
`define BPC_ADDR_OCV_CHG 8'h04
`define BPC_ADDR_OC_DELAY 8'h05
`define BPC_ADDR_SHORT_THRESH 8'h07
`define BPC_ADDR_SHORT_DELAY 8'h08
// Reset values
`define BPC_RESET_BYTE 8'h00
`define BPC_RESET_OCV 5'h00
`define BPC_RESET_SCV 4'h0
// Control register bit positions
`define BPC_BIT_RELEASE 0
`define BPC_BIT_DSG 1
`define BPC_BIT_CHG 2
`define BPC_BIT_PRECHARGE_SWITCH_OFF_OFF 3
`define BPC_BIT_MON_OFF 4
`define BPC_BIT_LED 5
`define BPC_BIT_THERM 6
`define BPC_BIT_SDM_OFF 7
// Unused upper bits of the narrow registers read as zero
`define BPC_PAD_OCV 3'h0
`define BPC_PAD_SCV 4'h0
// Timing, in microseconds, and clock rate
`define BPC_CLK_MHZ 100
`define BPC_OC_BASE_US 1000
`define BPC_OC_STEP_US 2000
`define BPC_SC_STEP_US 61
// Delay channel numbering
`define BPC_CH_OC_DSG 0
`define BPC_CH_OC_CHG 1
`define BPC_CH_SC_DSG 2
`define BPC_CH_SC_CHG 3
`endif

// [verilog/bpc_delay_timer.v]
// Blanking delay counter for one protection comparator channel
`timescale 1ns/10ps
module bpc_delay_timer #(
   parameter CNT_W = 24
) (
   input wire clock,
   input wire reset,
   input wire over,
   input wire [CNT_W-1:0] limit,
   output reg trip
);
   // Cycles the comparator has been continuously over threshold
   reg [CNT_W-1:0] count;
   // All ones, used to stop the count from wrapping
   wire [CNT_W-1:0] count_max = {CNT_W{1'b1}};

   // Count while over, restart as soon as the input drops
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         count <= {CNT_W{1'b0}};
         trip <= 1'b0;
      end else if (over) begin
         // Saturate so a long fault never looks like a fresh one
         if (count != count_max) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // Strictly longer than the delay before tripping
         trip <= (count >= limit);
      end else begin
         // Below threshold: restart the blanking period
         count <= {CNT_W{1'b0}};
         trip <= 1'b0;
      end
   end
endmodule

// [verilog/bpc_regs.v]
// Control and configuration registers with autonomous overcurrent latch
`timescale 1ns/10ps
`include "bpc_defines.vh"
module bpc_regs #(
   // Cycles for the 1 ms base of the overcurrent delay
   parameter [31:0] OC_BASE_CYC = `BPC_OC_BASE_US * `BPC_CLK_MHZ,
   // Cycles per overcurrent delay step of 2 ms
   parameter [31:0] OC_STEP_CYC = `BPC_OC_STEP_US * `BPC_CLK_MHZ,
   // Cycles per short-circuit delay step of 61 us
   parameter [31:0] SC_STEP_CYC = `BPC_SC_STEP_US * `BPC_CLK_MHZ,
   // Counter width; must hold the longest delay
   parameter CNT_W = 24
) (
   input wire clock,
   input wire reset,
   // Register access port from the serial slave front end
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_address,
   input wire [7:0] reg_write_data,
   output reg [7:0] reg_read_data,
   output reg reg_read_valid,
   // Comparator levels from the analog front end
   input wire discharge_overcurrent_over,
   input wire charge_overcurrent_over,
   input wire short_over_discharge,
   input wire short_over_charge,
   // Switch drives
   output reg discharge_switch_on,
   output reg charge_switch_on,
   output reg precharge_switch_off,
   // Analog enables
   output reg cell_monitor_disable,
   output reg led_drive_enable,
   output reg thermistor_power_on,
   output reg shutdown_monitor_disable,
   // Threshold codes to the analog comparators; delay codes stay internal
   output reg [3:0] shutdown_threshold_code,
   output reg [3:0] brownout_threshold_code,
   output reg [4:0] discharge_overcurrent_code,
   output reg [4:0] charge_overcurrent_code,
   output reg [3:0] short_threshold_code,
   // Latch state for the host
   output reg alert_output
);
   // Control register, all bits
   reg [7:0] output_control;
   // Shutdown and brownout threshold register
   reg [7:0] shutdown_brownout_threshold;
   // Overcurrent delay register, two nibbles
   reg [7:0] overcurrent_delay;
   // Short-circuit delay register, two nibbles
   reg [7:0] short_circuit_delay;
   // Overcurrent latch, discharge side
   reg dsg_latched;
   // Overcurrent latch, charge side
   reg chg_latched;
   // Release bit was raised while a latch was set
   reg release_armed;
   // Next values of the latches
   reg next_dsg_latched;
   reg next_chg_latched;
   reg next_release_armed;

   // Decoded write strobes
   wire wr_control = reg_write && (reg_address == `BPC_ADDR_CONTROL);
   wire wr_thresh = reg_write && (reg_address == `BPC_ADDR_THRESH);
   wire wr_ocv_dsg = reg_write && (reg_address == `BPC_ADDR_OCV_DSG);
   wire wr_ocv_chg = reg_write && (reg_address == `BPC_ADDR_OCV_CHG);
   wire wr_oc_delay = reg_write && (reg_address == `BPC_ADDR_OC_DELAY);
   wire wr_sc_thresh = reg_write && (reg_address == `BPC_ADDR_SHORT_THRESH);
   wire wr_sc_delay = reg_write && (reg_address == `BPC_ADDR_SHORT_DELAY);

   // Comparator levels, one bit per delay channel
   wire [3:0] chan_over;
   // Delay codes, one nibble per channel
   wire [15:0] chan_code;
   // Registered trip of each channel
   wire [3:0] chan_trip;

   assign chan_over = {short_over_charge, short_over_discharge,
                       charge_overcurrent_over, discharge_overcurrent_over};
   assign chan_code = {short_circuit_delay[7:4], short_circuit_delay[3:0],
                       overcurrent_delay[7:4], overcurrent_delay[3:0]};

   // One delay counter per comparator channel
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
         // Overcurrent channels carry a base time, short channels do not
         localparam IS_OC = (ch == `BPC_CH_OC_DSG) || (ch == `BPC_CH_OC_CHG);
         localparam [31:0] BASE = IS_OC ? OC_BASE_CYC : 32'h0;
         localparam [31:0] STEP = IS_OC ? OC_STEP_CYC : SC_STEP_CYC;
         // Full-width limit, cut to the counter width below
         wire [31:0] limit_full;
         // Linear code to cycles: base plus step per code
         assign limit_full = BASE + STEP * {28'h0, chan_code[ch*4 +: 4]};
         bpc_delay_timer #(
            .CNT_W(CNT_W)
         ) u_timer (
            .clock(clock),
            .reset(reset),
            .over(chan_over[ch]),
            .limit(limit_full[CNT_W-1:0]),
            .trip(chan_trip[ch])
         );
      end
   endgenerate

   // Trips grouped by the switch they affect
   wire dsg_trip = chan_trip[`BPC_CH_OC_DSG] | chan_trip[`BPC_CH_SC_DSG];
   wire chg_trip = chan_trip[`BPC_CH_OC_CHG] | chan_trip[`BPC_CH_SC_CHG];
   // Either latch set
   wire any_latched = dsg_latched | chg_latched;
   // Host raises the release bit from 0 to 1 while latched
   wire release_rise = wr_control && reg_write_data[`BPC_BIT_RELEASE] &&
                       !output_control[`BPC_BIT_RELEASE] && any_latched;
   // Host drops the release bit back to 0 after arming
   wire release_fall = wr_control && !reg_write_data[`BPC_BIT_RELEASE] &&
                       output_control[`BPC_BIT_RELEASE] && release_armed;
   // Control value as it stands after this cycle
   wire [7:0] control_now = wr_control ? reg_write_data : output_control;

   // Latch next state; a trip in the release cycle wins
   always @* begin
      next_dsg_latched = dsg_latched;
      next_chg_latched = chg_latched;
      next_release_armed = release_armed;
      if (release_fall) begin
         // Full 0-1-0 sequence completed
         next_dsg_latched = 1'b0;
         next_chg_latched = 1'b0;
         next_release_armed = 1'b0;
      end else if (release_rise) begin
         // First half of the release sequence
         next_release_armed = 1'b1;
      end
      if (dsg_trip) begin
         // Expired discharge delay sets the latch
         next_dsg_latched = 1'b1;
      end
      if (chg_trip) begin
         // Expired charge delay sets the latch
         next_chg_latched = 1'b1;
      end
   end

   // Latch flip-flops
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         dsg_latched <= 1'b0;
         chg_latched <= 1'b0;
         release_armed <= 1'b0;
      end else begin
         dsg_latched <= next_dsg_latched;
         chg_latched <= next_chg_latched;
         release_armed <= next_release_armed;
      end
   end

   // Register writes; everything clears at power up
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         output_control <= `BPC_RESET_BYTE;
         shutdown_brownout_threshold <= `BPC_RESET_BYTE;
         discharge_overcurrent_code <= `BPC_RESET_OCV;
         charge_overcurrent_code <= `BPC_RESET_OCV;
         overcurrent_delay <= `BPC_RESET_BYTE;
         short_threshold_code <= `BPC_RESET_SCV;
         short_circuit_delay <= `BPC_RESET_BYTE;
      end else begin
         if (wr_control) begin
            // Bit 0 is stored so the release edge can be seen
            output_control <= reg_write_data;
         end
         if (wr_thresh) begin
            // Two threshold nibbles in one byte
            shutdown_brownout_threshold <= reg_write_data;
         end
         if (wr_ocv_dsg) begin
            // Upper three bits are dropped
            discharge_overcurrent_code <= reg_write_data[4:0];
         end
         if (wr_ocv_chg) begin
            // Same five-bit coding as discharge
            charge_overcurrent_code <= reg_write_data[4:0];
         end
         if (wr_oc_delay) begin
            overcurrent_delay <= reg_write_data;
         end
         if (wr_sc_thresh) begin
            // One threshold serves both directions
            short_threshold_code <= reg_write_data[3:0];
         end
         if (wr_sc_delay) begin
            short_circuit_delay <= reg_write_data;
         end
      end
   end

   // Output drives; registered so every pin comes from a flop
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         discharge_switch_on <= 1'b0;
         charge_switch_on <= 1'b0;
         precharge_switch_off <= 1'b0;
         cell_monitor_disable <= 1'b0;
         led_drive_enable <= 1'b0;
         thermistor_power_on <= 1'b0;
         shutdown_monitor_disable <= 1'b0;
         shutdown_threshold_code <= 4'h0;
         brownout_threshold_code <= 4'h0;
         alert_output <= 1'b0;
      end else begin
         // Host bit gated by the latch, which overrides the host
         discharge_switch_on <= control_now[`BPC_BIT_DSG] & ~next_dsg_latched;
         // Same gating on the charge side
         charge_switch_on <= control_now[`BPC_BIT_CHG] & ~next_chg_latched;
         // Inverted sense: zero leaves precharge on
         precharge_switch_off <= control_now[`BPC_BIT_PRECHARGE_SWITCH_OFF_OFF];
         // One bit stops both translation and balancing
         cell_monitor_disable <= control_now[`BPC_BIT_MON_OFF];
         // LED current source enable
         led_drive_enable <= control_now[`BPC_BIT_LED];
         // Thermistor supply switch
         thermistor_power_on <= control_now[`BPC_BIT_THERM];
         // Shutdown monitor off when set
         shutdown_monitor_disable <= control_now[`BPC_BIT_SDM_OFF];
         // Regulator shutdown code, low nibble
         shutdown_threshold_code <= shutdown_brownout_threshold[3:0];
         // Brownout code, high nibble
         brownout_threshold_code <= shutdown_brownout_threshold[7:4];
         // Alert stays up until release; status read is not in this block
         alert_output <= next_dsg_latched | next_chg_latched;
      end
   end

   // Read data mux; unmapped and unused bits read zero
   reg [7:0] read_mux;
   always @* begin
      read_mux = 8'h00;
      case (reg_address)
         `BPC_ADDR_CONTROL: begin
            read_mux = output_control;
         end
         `BPC_ADDR_THRESH: begin
            read_mux = shutdown_brownout_threshold;
         end
         `BPC_ADDR_OCV_DSG: begin
            read_mux = {`BPC_PAD_OCV, discharge_overcurrent_code};
         end
         `BPC_ADDR_OCV_CHG: begin
            read_mux = {`BPC_PAD_OCV, charge_overcurrent_code};
         end
         `BPC_ADDR_OC_DELAY: begin
            read_mux = overcurrent_delay;
         end
         `BPC_ADDR_SHORT_THRESH: begin
            read_mux = {`BPC_PAD_SCV, short_threshold_code};
         end
         `BPC_ADDR_SHORT_DELAY: begin
            read_mux = short_circuit_delay;
         end
         default: begin
            // Status and cell select live elsewhere
            read_mux = 8'h00;
         end
      endcase
   end

   // Read answer one cycle after the strobe
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_read_data <= 8'h00;
         reg_read_valid <= 1'b0;
      end else begin
         reg_read_valid <= reg_read;
         if (reg_read) begin
            // Data holds until the next read
            reg_read_data <= read_mux;
         end
      end
   end
endmodule

// [verification/bpc_regs_sva.sv]
// Port-level assertions for the battery protection configuration register bank
`timescale 1ns/10ps
module bpc_regs_sva (
   input wire clock,
   input wire reset,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_address,
   input wire [7:0] reg_write_data,
   input wire [7:0] reg_read_data,
   input wire reg_read_valid,
   input wire discharge_overcurrent_over,
   input wire charge_overcurrent_over,
   input wire short_over_discharge,
   input wire short_over_charge,
   input wire discharge_switch_on,
   input wire charge_switch_on,
   input wire precharge_switch_off,
   input wire cell_monitor_disable,
   input wire [3:0] shutdown_threshold_code,
   input wire [3:0] brownout_threshold_code,
   input wire alert_output
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Any comparator above its threshold
   wire any_over = discharge_overcurrent_over | charge_overcurrent_over |
      short_over_discharge | short_over_charge;
   // Host write to the control register
   wire ctrl_wr = reg_write && reg_address == 8'h01;
   // Shadow of the discharge short delay code, so the zero-delay case can be spotted
   reg [3:0] sc_dsg_code;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sc_dsg_code <= 4'h0;
      end else if (reg_write && reg_address == 8'h08) begin
         sc_dsg_code <= reg_write_data[3:0];
      end
   end
   sequence s_ocv_write;
      reg_write && reg_address == 8'h03;
   endsequence
   sequence s_ocv_read;
      reg_read && !reg_write && reg_address == 8'h03;
   endsequence
   // Zero delay: a single high sample is already longer than the delay
   sequence s_short_zero;
      short_over_discharge && sc_dsg_code == 4'h0;
   endsequence
   a_ocv_readback: assert property (s_ocv_write ##1 !reg_write ##1 s_ocv_read |=>
      reg_read_valid && reg_read_data == {3'h0, $past(reg_write_data[4:0], 3)})
      else $error("discharge overcurrent code read back wrong");
   a_aux_bits: assert property (ctrl_wr |=>
      precharge_switch_off == $past(reg_write_data[3]) &&
      cell_monitor_disable == $past(reg_write_data[4]))
      else $error("control enable bit not copied");
   a_thresh_codes: assert property ((reg_write && reg_address == 8'h02) |=> ##1
      {brownout_threshold_code, shutdown_threshold_code} == $past(reg_write_data, 2))
      else $error("threshold codes wrong");
   a_dsg_write: assert property (ctrl_wr && !alert_output && !any_over |=>
      alert_output || discharge_switch_on == $past(reg_write_data[1]))
      else $error("discharge switch does not follow control");
   a_chg_write: assert property (ctrl_wr && !alert_output && !any_over |=>
      alert_output || charge_switch_on == $past(reg_write_data[2]))
      else $error("charge switch does not follow control");
   a_short_zero: assert property (s_short_zero |=> ##1
      !discharge_switch_on && alert_output)
      else $error("zero-delay short did not open discharge switch");
   a_alert_cause: assert property ($rose(alert_output) |-> $past(any_over, 2))
      else $error("latch set without comparator cause");
   a_latch_release: assert property ($fell(alert_output) |->
      $past(ctrl_wr && !reg_write_data[0])) else $error("latch cleared without release write");
   a_latch_forces_off: assert property (alert_output |-> !discharge_switch_on ||
      !charge_switch_on) else $error("switches on while latched");
endmodule

// [verification/bpc_host_model.sv]
// Host controller model driving the byte register port
`timescale 1ns/10ps
module bpc_host_model (
   input wire clock,
   output reg reg_write,
   output reg reg_read,
   output reg [7:0] reg_address,
   output reg [7:0] reg_write_data,
   input wire [7:0] reg_read_data,
   input wire reg_read_valid
);
   // Idle bus at time zero
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_address = 8'h00;
      reg_write_data = 8'h00;
   end
   // One byte write; address and data are scrambled once taken, never left stale
   task wr_byte(input [7:0] a, input [7:0] d);
      begin
         @(posedge clock);
         reg_write <= 1'b1;
         reg_address <= a;
         reg_write_data <= d;
         @(posedge clock);
         reg_write <= 1'b0;
         reg_address <= ~a;
         reg_write_data <= ~d;
      end
   endtask
   // One byte read; answer is sampled just after the edge that takes the request
   task rd_byte(input [7:0] a, output [7:0] d, output v);
      begin
         @(posedge clock);
         reg_read <= 1'b1;
         reg_address <= a;
         @(posedge clock);
         reg_read <= 1'b0;
         reg_address <= ~a;
         #1;
         d = reg_read_data;
         v = reg_read_valid;
      end
   endtask
   // Latch release toggles bit 0 low, high, low in three control writes
   task release_latch(input [7:0] c);
      begin
         wr_byte(8'h01, c & 8'hfe);
         wr_byte(8'h01, c | 8'h01);
         wr_byte(8'h01, c & 8'hfe);
      end
   endtask
endmodule

// [verification/tb_battery_protect_config_regs.sv]
// Self-checking bench for the protection configuration register bank
`timescale 1ns/10ps
module tb_battery_protect_config_regs;
   // Short delay scales keep trip delays to at most 124 cycles
   localparam [31:0] OC_B = 4;
   localparam [31:0] OC_S = 8;
   localparam [31:0] SC_S = 3;
   reg clock = 1'b0;
   reg reset = 1'b1;
   reg [3:0] over_in = 4'h0;
   wire wr, rd, rvalid, dsg_on, chg_on, precharge_switch_off_off, mon_dis, led_en, therm_on, sdm_dis, alert;
   wire [7:0] addr, wdata, rdata;
   wire [3:0] sd_code, bo_code, sc_code;
   wire [4:0] ocd_code, occ_code;
   wire [28:0] outs = {sdm_dis, therm_on, led_en, mon_dis, precharge_switch_off_off, chg_on, dsg_on, bo_code,
      sd_code, ocd_code, occ_code, sc_code};
   integer num_errors = 0;
   integer check_count = 0;
   integer i, ch;
   reg [7:0] a, d, got;
   reg v;
   reg [3:0] code;
   reg [7:0] mirror [0:8];
   always #5 clock = ~clock;
   bpc_regs #(.OC_BASE_CYC(OC_B), .OC_STEP_CYC(OC_S), .SC_STEP_CYC(SC_S)) uut (
      .clock(clock), .reset(reset), .reg_write(wr), .reg_read(rd), .reg_address(addr),
      .reg_write_data(wdata), .reg_read_data(rdata), .reg_read_valid(rvalid),
      .discharge_overcurrent_over(over_in[0]), .charge_overcurrent_over(over_in[1]),
      .short_over_discharge(over_in[2]), .short_over_charge(over_in[3]),
      .discharge_switch_on(dsg_on), .charge_switch_on(chg_on), .precharge_switch_off(precharge_switch_off_off),
      .cell_monitor_disable(mon_dis), .led_drive_enable(led_en), .thermistor_power_on(therm_on),
      .shutdown_monitor_disable(sdm_dis), .shutdown_threshold_code(sd_code),
      .brownout_threshold_code(bo_code), .discharge_overcurrent_code(ocd_code),
      .charge_overcurrent_code(occ_code), .short_threshold_code(sc_code), .alert_output(alert));
   bpc_host_model host (.clock(clock), .reg_write(wr), .reg_read(rd), .reg_address(addr),
      .reg_write_data(wdata), .reg_read_data(rdata), .reg_read_valid(rvalid));
   // Implemented bits of each offset; reserved places read zero
   function [7:0] mask_of(input [7:0] ad);
      case (ad)
         8'h01, 8'h02, 8'h05, 8'h08: mask_of = 8'hff;
         8'h03, 8'h04: mask_of = 8'h1f;
         8'h07: mask_of = 8'h0f;
         default: mask_of = 8'h00;
      endcase
   endfunction
   // Output pins expected from the register contents
   function [28:0] exp_outs();
      exp_outs = {mirror[1][7:1], mirror[2], mirror[3][4:0], mirror[4][4:0], mirror[7][3:0]};
   endfunction
   // Trip delay in cycles: overcurrent channels have a base, short channels do not
   function [31:0] limit_of(input integer c, input [3:0] cd);
      limit_of = (c < 2) ? OC_B + OC_S * cd : SC_S * cd;
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks=%0d errors=%0d", check_count, num_errors);
         if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Pins and every offset, reserved ones included, against the mirror
   task check_all;
      integer k;
      begin
         @(posedge clock);
         #1 check(outs, exp_outs());
         for (k = 0; k < 9; k = k + 1) begin
            host.rd_byte(k[7:0], got, v);
            check({v, got}, {1'b1, mirror[k] & mask_of(k[7:0])});
         end
      end
   endtask
   // One channel: exactly the delay must not trip, one sample more must
   task trip_test(input integer c, input [3:0] cd);
      integer lim, n;
      reg [1:0] sw;
      begin
         lim = limit_of(c, cd);
         sw = (c % 2) ? 2'b10 : 2'b01;
         host.wr_byte(8'h01, 8'h06);
         host.wr_byte((c < 2) ? 8'h05 : 8'h08, (c % 2) ? {cd, 4'h0} : {4'h0, cd});
         if (lim > 0) begin
            over_in[c] <= 1'b1;
            repeat (lim) @(posedge clock);
            over_in[c] <= 1'b0;
         end
         repeat (3) @(posedge clock);
         #1 check({alert, dsg_on, chg_on}, 3'b011);
         @(posedge clock);
         over_in[c] <= 1'b1;
         n = 0;
         while (alert !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1 n = n + 1;
         end
         check(n, lim + 2);
         check({dsg_on, chg_on}, sw);
         @(posedge clock);
         over_in[c] <= 1'b0;
         host.wr_byte(8'h01, 8'h06);
         #1 check({alert, dsg_on, chg_on}, {1'b1, sw});
         host.release_latch(8'h06);
         #1 check({alert, dsg_on, chg_on}, 3'b011);
      end
   endtask
   initial begin
      i = $urandom(32'h4681de88);
      for (i = 0; i < 9; i = i + 1)
         mirror[i] = 8'h00;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      check_all;
      // All-ones to every offset first, then random bytes
      for (i = 0; i < 24; i = i + 1) begin
         a = (i < 9) ? i[7:0] : 8'($urandom % 9);
         d = (i < 9) ? 8'hff : 8'($urandom);
         host.wr_byte(a, d);
         mirror[a] = d & mask_of(a);
         check_all;
      end
      host.wr_byte(8'h03, 8'hea);
      host.rd_byte(8'h03, got, v);
      check(got, 8'h0a);
      // Reset in mid-run brings everything back to zero
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i < 9; i = i + 1)
         mirror[i] = 8'h00;
      check_all;
      for (ch = 0; ch < 4; ch = ch + 1) begin
         for (i = 0; i < 3; i = i + 1) begin
            code = (i == 0) ? 4'h0 : (i == 2) ? 4'hf : 4'($urandom);
            trip_test(ch, code);
         end
      end
      report_and_stop;
   end
   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      #300000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
endmodule
bind bpc_regs bpc_regs_sva chk (.clock(clock), .reset(reset), .reg_write(reg_write),
   .reg_read(reg_read), .reg_address(reg_address), .reg_write_data(reg_write_data),
   .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
   .discharge_overcurrent_over(discharge_overcurrent_over),
   .charge_overcurrent_over(charge_overcurrent_over), .short_over_discharge(short_over_discharge),
   .short_over_charge(short_over_charge), .discharge_switch_on(discharge_switch_on),
   .charge_switch_on(charge_switch_on), .precharge_switch_off(precharge_switch_off),
   .cell_monitor_disable(cell_monitor_disable), .shutdown_threshold_code(shutdown_threshold_code),
   .brownout_threshold_code(brownout_threshold_code), .alert_output(alert_output));
